// ===== hw/pcd_cable_test.sv
`timescale 1ns/1ps
module pcd_cable_test
	import pcd_pkg::*;
#(
	parameter int TIMEOUT_CYC = SILENCE_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Control side
	pcd_cdt_if.eng cdt,
	// Analog front end
	input wire logic i_partner_silent,
	input wire logic i_echo_seen,
	input wire logic i_echo_short,
	output logic o_quiet_req,
	output logic o_tdr_pulse
);
	if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 4095) begin : g_bad_timeout
		$error("TIMEOUT_CYC out of range");
	end

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_QUIET = 4'b0010,
		ST_PULSE = 4'b0100,
		ST_MEAS = 4'b1000
	} pcd_cdt_state_t;

	pcd_cdt_state_t state;
	logic [11:0] timer;

	assign cdt.busy = (state != ST_IDLE);
	assign o_quiet_req = (state != ST_IDLE);
	assign o_tdr_pulse = (state == ST_PULSE);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= ST_IDLE;
			timer <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					timer <= '0;
					if (cdt.start) state <= ST_QUIET;
				end
				ST_QUIET: begin
					timer <= timer + 12'h001;
					if (i_partner_silent) state <= ST_PULSE;
					else if (timer == 12'(TIMEOUT_CYC - 1)) state <= ST_IDLE;
				end
				ST_PULSE: state <= ST_MEAS;
				ST_MEAS: begin
					if (i_echo_seen || cdt.count == FAULT_COUNT_MAX) state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Results clear only when a new test starts, so software can read them at leisure.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cdt.result <= CDT_NORMAL;
			cdt.count <= '0;
		end else if (state == ST_IDLE && cdt.start) begin
			cdt.result <= CDT_NORMAL;
			cdt.count <= '0;
		end else if (state == ST_QUIET && !i_partner_silent && timer == 12'(TIMEOUT_CYC - 1)) begin
			cdt.result <= CDT_INVALID;
		end else if (state == ST_MEAS) begin
			if (i_echo_seen) cdt.result <= i_echo_short ? CDT_SHORT : CDT_OPEN;
			else if (cdt.count != FAULT_COUNT_MAX) cdt.count <= cdt.count + 9'h001;
		end
	end

	property p_timeout_invalid;
		@(posedge i_clk) disable iff (i_srst)
		(state == ST_QUIET && !i_partner_silent && timer == 12'(TIMEOUT_CYC - 1))
			|=> (cdt.result == CDT_INVALID) && !cdt.busy;
	endproperty
	a_timeout_invalid: assert property (p_timeout_invalid) else $error("timeout did not give invalid result");

	property p_count_range;
		@(posedge i_clk) disable iff (i_srst) cdt.count <= FAULT_COUNT_MAX;
	endproperty
	a_count_range: assert property (p_count_range) else $error("fault count beyond range");

	property p_pulse_once;
		@(posedge i_clk) disable iff (i_srst) o_tdr_pulse |=> !o_tdr_pulse && (state == ST_MEAS);
	endproperty
	a_pulse_once: assert property (p_pulse_once) else $error("pulse not single");

	property p_hold;
		@(posedge i_clk) disable iff (i_srst)
		(!cdt.busy && !cdt.start) |=> $stable(cdt.result) && $stable(cdt.count);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed while idle");

	c_invalid: cover property (@(posedge i_clk) disable iff (i_srst) cdt.result == CDT_INVALID);
	c_short: cover property (@(posedge i_clk) disable iff (i_srst) cdt.result == CDT_SHORT);
endmodule : pcd_cable_test

// ===== hw/pcd_cdt_if.sv
`timescale 1ns/1ps
interface pcd_cdt_if;
	logic start;
	logic busy;
	logic [1:0] result;
	logic [8:0] count;
	modport ctrl (output start, input busy, input result, input count);
	modport eng (input start, output busy, output result, output count);
endinterface : pcd_cdt_if

// ===== hw/pcd_link_mode.sv
`timescale 1ns/1ps
module pcd_link_mode
	import pcd_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Abilities
	input wire logic [3:0] i_local_adv,
	input wire logic [3:0] i_partner_adv,
	input wire logic i_adv_valid,
	// Parallel detection
	input wire logic i_pd_100,
	input wire logic i_pd_10,
	// Result
	output pcd_mode_t o_mode,
	output logic o_link_up
);
	function automatic logic [2:0] best_mode(input logic [3:0] common);
		if (common[ABIL_100_FD]) return {1'b1, MODE_100_FD};
		if (common[ABIL_100_HD]) return {1'b1, MODE_100_HD};
		if (common[ABIL_10_FD]) return {1'b1, MODE_10_FD};
		return {common[ABIL_10_HD], MODE_10_HD};
	endfunction : best_mode

	logic [2:0] pick;
	assign pick = best_mode(i_local_adv & i_partner_adv);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_mode <= MODE_10_HD;
			o_link_up <= 1'b0;
		end else if (i_adv_valid) begin
			o_mode <= pcd_mode_t'(pick[1:0]);
			o_link_up <= pick[2];
		end else if (i_pd_100) begin
			o_mode <= MODE_100_HD;
			o_link_up <= 1'b1;
		end else if (i_pd_10) begin
			o_mode <= MODE_10_HD;
			o_link_up <= 1'b1;
		end else begin
			o_link_up <= 1'b0;
		end
	end

	property p_best_100fd;
		@(posedge i_clk) disable iff (i_srst)
		(i_adv_valid && i_local_adv[ABIL_100_FD] && i_partner_adv[ABIL_100_FD]) |=> o_mode == MODE_100_FD && o_link_up;
	endproperty
	a_best_100fd: assert property (p_best_100fd) else $error("best mode not chosen");

	property p_pd_100;
		@(posedge i_clk) disable iff (i_srst)
		(!i_adv_valid && i_pd_100) |=> o_mode == MODE_100_HD && o_link_up;
	endproperty
	a_pd_100: assert property (p_pd_100) else $error("parallel detect failed");
endmodule : pcd_link_mode

// ===== hw/pcd_phy_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - MDI transmits pair one; MDI-X swaps pairs.
// - Pick best common mode, 100 full first.
// - Negotiation only on the copper ports.
// - No advertisements: mode from detected signalling.
// - Control bit 2 disables auto crossover.
// - Bit 4 starts test, self-clears when done.
// - Result bits 6:5 normal/open/short/invalid.
// - Partner not silenced gives invalid, no measurement.
// - Nine-bit distance count, ctrl bit 0 MSB.
// - Separate test registers for each copper port.
// - Same test reachable through PHY register 1d; crossover bits through register 0.
// - Distance range 200 m, copper only.
module pcd_phy_ctrl
	import pcd_pkg::*;
#(
	parameter int NUM_PORTS = 3,
	parameter int TIMEOUT_CYC = SILENCE_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Management register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Alternate PHY register path
	input wire logic [1:0] i_miim_phy,
	input wire logic [4:0] i_miim_reg,
	input wire logic i_miim_wr,
	input wire logic i_miim_rd,
	input wire logic [15:0] i_miim_wdata,
	output logic [15:0] o_miim_rdata,
	// Pair routing per port
	input wire logic [NUM_PORTS-1:0] i_tx_pair_pos,
	input wire logic [NUM_PORTS-1:0] i_tx_pair_neg,
	input wire logic [NUM_PORTS-1:0][1:0] i_rx_pair1,
	input wire logic [NUM_PORTS-1:0][1:0] i_rx_pair2,
	input wire logic [NUM_PORTS-1:0] i_remote_on_pair1,
	output logic [NUM_PORTS-1:0][1:0] o_pair1_drive,
	output logic [NUM_PORTS-1:0][1:0] o_pair2_drive,
	output logic [NUM_PORTS-1:0][1:0] o_rx_data,
	output logic [NUM_PORTS-1:0] o_mdix,
	// Negotiation per port
	input wire logic [NUM_PORTS-1:0][3:0] i_local_adv,
	input wire logic [NUM_PORTS-1:0][3:0] i_partner_adv,
	input wire logic [NUM_PORTS-1:0] i_adv_valid,
	input wire logic [NUM_PORTS-1:0] i_pd_100,
	input wire logic [NUM_PORTS-1:0] i_pd_10,
	output pcd_mode_t [NUM_PORTS-1:0] o_mode,
	output logic [NUM_PORTS-1:0] o_link_up,
	// Reflectometer front end per port
	input wire logic [NUM_PORTS-1:0] i_partner_silent,
	input wire logic [NUM_PORTS-1:0] i_echo_seen,
	input wire logic [NUM_PORTS-1:0] i_echo_short,
	output logic [NUM_PORTS-1:0] o_quiet_req,
	output logic [NUM_PORTS-1:0] o_tdr_pulse
);
	if (NUM_PORTS != 3) begin : g_bad_ports
		$error("NUM_PORTS must be 3, one per copper port");
	end

	// ==========================================================
	// Address decode
	// ==========================================================
	// Returns {hit, kind[1:0], port[1:0]}; kind 0 ctrl, 1 result, 2 crossover.
	function automatic logic [4:0] decode(input logic [7:0] addr);
		for (int p = 0; p < 3; p++) begin
			if (addr == CDT_CTRL_OFS[p]) return {1'b1, 2'h0, 2'(p)};
			if (addr == CDT_RES_OFS[p]) return {1'b1, 2'h1, 2'(p)};
			if (addr == XOVER_CTRL_OFS[p]) return {1'b1, 2'h2, 2'(p)};
		end
		return 5'h00;
	endfunction : decode

	function automatic logic miim_hit(input logic [1:0] phy, input logic [4:0] regn, input logic [4:0] want,
		input int p);
		return (phy == 2'(p + 1)) && (regn == want);
	endfunction : miim_hit

	logic [4:0] dec;
	assign dec = decode(i_reg_addr);

	// ==========================================================
	// Per-port state
	// ==========================================================
	logic [NUM_PORTS-1:0][7:0] xover;
	logic [NUM_PORTS-1:0] start;
	logic [NUM_PORTS-1:0] busy;
	logic [NUM_PORTS-1:0][1:0] result;
	logic [NUM_PORTS-1:0][8:0] count;
	logic [NUM_PORTS-1:0][7:0] ctrl_view;
	logic [NUM_PORTS-1:0][15:0] miim_basic_view;
	logic [NUM_PORTS-1:0][15:0] miim_cdt_view;

	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			pcd_cdt_if cdt ();
			logic reg_start;
			logic miim_start;
			logic reg_xo_wr;
			logic miim_xo_wr;

			// each port has its own test registers
			assign reg_start = i_reg_wr && dec[4] && dec[3:2] == 2'h0 && dec[1:0] == 2'(p)
				&& i_reg_wdata[CTRL_START_BIT];
			assign miim_start = i_miim_wr && miim_hit(i_miim_phy, i_miim_reg, MIIM_CDT_REG, p)
				&& i_miim_wdata[MIIM_START_BIT];
			assign cdt.start = (reg_start || miim_start) && !cdt.busy;
			assign start[p] = cdt.start;
			assign busy[p] = cdt.busy;
			assign result[p] = cdt.result;
			assign count[p] = cdt.count;

			// start bit reads busy, clears itself when the test ends
			always_comb begin
				ctrl_view[p] = 8'h00;
				ctrl_view[p][CTRL_RES_LSB +: 2] = cdt.result;
				ctrl_view[p][CTRL_START_BIT] = cdt.busy;
				ctrl_view[p][CTRL_CNT_MSB_BIT] = cdt.count[8];
			end

			always_comb begin
				miim_basic_view[p] = 16'h0000;
				miim_basic_view[p][MIIM_DIS_AUTO_BIT] = xover[p][XOVER_DIS_AUTO_BIT];
				miim_basic_view[p][MIIM_FORCE_MDI_BIT] = xover[p][XOVER_FORCE_MDI_BIT];
				miim_cdt_view[p] = 16'h0000;
				miim_cdt_view[p][MIIM_START_BIT] = cdt.busy;
				miim_cdt_view[p][MIIM_RES_LSB +: 2] = cdt.result;
				miim_cdt_view[p][8:0] = cdt.count;
			end

			assign reg_xo_wr = i_reg_wr && dec[4] && dec[3:2] == 2'h2 && dec[1:0] == 2'(p);
			assign miim_xo_wr = i_miim_wr && miim_hit(i_miim_phy, i_miim_reg, MIIM_BASIC_REG, p);

			// Register port wins when both paths write in one cycle.
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					xover[p] <= CTRL_RESET;
				end else if (reg_xo_wr) begin
					xover[p] <= i_reg_wdata;
				end else if (miim_xo_wr) begin
					xover[p] <= 8'h00;
					xover[p][XOVER_DIS_AUTO_BIT] <= i_miim_wdata[MIIM_DIS_AUTO_BIT];
					xover[p][XOVER_FORCE_MDI_BIT] <= i_miim_wdata[MIIM_FORCE_MDI_BIT];
				end
			end

			// auto sense unless disabled; forced MDI-X when bit 1 is clear
			assign o_mdix[p] = xover[p][XOVER_DIS_AUTO_BIT] ? !xover[p][XOVER_FORCE_MDI_BIT]
				: i_remote_on_pair1[p];

			// pair roles follow the crossover state
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					o_pair1_drive[p] <= 2'h0;
					o_pair2_drive[p] <= 2'h0;
					o_rx_data[p] <= 2'h0;
				end else if (o_mdix[p]) begin
					o_pair1_drive[p] <= 2'h0;
					o_pair2_drive[p] <= {i_tx_pair_pos[p], i_tx_pair_neg[p]};
					o_rx_data[p] <= i_rx_pair1[p];
				end else begin
					o_pair1_drive[p] <= {i_tx_pair_pos[p], i_tx_pair_neg[p]};
					o_pair2_drive[p] <= 2'h0;
					o_rx_data[p] <= i_rx_pair2[p];
				end
			end

			pcd_cable_test #(
				.TIMEOUT_CYC(TIMEOUT_CYC)
			) u_cdt (
				.i_clk(i_clk),
				.i_srst(i_srst),
				.cdt(cdt.eng),
				.i_partner_silent(i_partner_silent[p]),
				.i_echo_seen(i_echo_seen[p]),
				.i_echo_short(i_echo_short[p]),
				.o_quiet_req(o_quiet_req[p]),
				.o_tdr_pulse(o_tdr_pulse[p])
			);

			// negotiation exists only on copper ports
			pcd_link_mode u_link (
				.i_clk(i_clk),
				.i_srst(i_srst),
				.i_local_adv(i_local_adv[p]),
				.i_partner_adv(i_partner_adv[p]),
				.i_adv_valid(i_adv_valid[p]),
				.i_pd_100(i_pd_100[p]),
				.i_pd_10(i_pd_10[p]),
				.o_mode(o_mode[p]),
				.o_link_up(o_link_up[p])
			);
		end
	endgenerate

	// ==========================================================
	// Read data
	// ==========================================================
	// Reads are registered; unmapped addresses answer zero.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			if (!dec[4]) o_reg_rdata <= 8'h00;
			else if (dec[3:2] == 2'h0) o_reg_rdata <= ctrl_view[dec[1:0]];
			else if (dec[3:2] == 2'h1) o_reg_rdata <= count[dec[1:0]][7:0];
			else o_reg_rdata <= xover[dec[1:0]];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_miim_rdata <= 16'h0000;
		end else if (i_miim_rd) begin
			if (i_miim_phy == 2'h0) o_miim_rdata <= 16'h0000;
			else if (i_miim_reg == MIIM_CDT_REG) o_miim_rdata <= miim_cdt_view[i_miim_phy - 2'h1];
			else if (i_miim_reg == MIIM_BASIC_REG) o_miim_rdata <= miim_basic_view[i_miim_phy - 2'h1];
			else o_miim_rdata <= 16'h0000;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	property p_start_busy;
		@(posedge i_clk) disable iff (i_srst) start[0] |=> busy[0] && ctrl_view[0][CTRL_START_BIT];
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("start did not raise busy");

	property p_forced_mdix;
		@(posedge i_clk) disable iff (i_srst)
		(xover[1][XOVER_DIS_AUTO_BIT] && !xover[1][XOVER_FORCE_MDI_BIT]) |-> o_mdix[1];
	endproperty
	a_forced_mdix: assert property (p_forced_mdix) else $error("forced MDI-X not applied");

	property p_mdi_route;
		@(posedge i_clk) disable iff (i_srst)
		!o_mdix[0] |=> o_pair1_drive[0] == {$past(i_tx_pair_pos[0]), $past(i_tx_pair_neg[0])}
			&& o_pair2_drive[0] == 2'h0;
	endproperty
	a_mdi_route: assert property (p_mdi_route) else $error("MDI pair routing wrong");

	property p_ctrl_read;
		@(posedge i_clk) disable iff (i_srst)
		(i_reg_rd && i_reg_addr == CDT_CTRL_OFS[2]) |=>
			o_reg_rdata[CTRL_RES_LSB +: 2] == $past(result[2]) && o_reg_rdata[CTRL_CNT_MSB_BIT] == $past(count[2][8]);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

	property p_unmapped;
		@(posedge i_clk) disable iff (i_srst) (i_reg_rd && !dec[4]) |=> o_reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_mdix_route;
		@(posedge i_clk) disable iff (i_srst)
		o_mdix[0] |=> o_pair2_drive[0] == {$past(i_tx_pair_pos[0]), $past(i_tx_pair_neg[0])}
			&& o_pair1_drive[0] == 2'h0 && o_rx_data[0] == $past(i_rx_pair1[0]);
	endproperty
	a_mdix_route: assert property (p_mdix_route) else $error("MDI-X pair routing wrong");

	property p_result_read;
		@(posedge i_clk) disable iff (i_srst)
		(i_reg_rd && i_reg_addr == CDT_RES_OFS[0]) |=> o_reg_rdata == $past(count[0][7:0]);
	endproperty
	a_result_read: assert property (p_result_read) else $error("result readback wrong");

	property p_xover_write;
		@(posedge i_clk) disable iff (i_srst)
		(i_reg_wr && i_reg_addr == XOVER_CTRL_OFS[2]) |=> xover[2] == $past(i_reg_wdata);
	endproperty
	a_xover_write: assert property (p_xover_write) else $error("crossover write lost");

	property p_miim_cdt_read;
		@(posedge i_clk) disable iff (i_srst)
		(i_miim_rd && i_miim_phy == 2'h2 && i_miim_reg == MIIM_CDT_REG) |=>
			o_miim_rdata[MIIM_RES_LSB +: 2] == $past(result[1]) && o_miim_rdata[8:0] == $past(count[1])
			&& o_miim_rdata[MIIM_START_BIT] == $past(busy[1]);
	endproperty
	a_miim_cdt_read: assert property (p_miim_cdt_read) else $error("alternate readback wrong");

	property p_miim_basic_read;
		@(posedge i_clk) disable iff (i_srst)
		(i_miim_rd && i_miim_phy == 2'h1 && i_miim_reg == MIIM_BASIC_REG) |=>
			o_miim_rdata[MIIM_DIS_AUTO_BIT] == $past(xover[0][XOVER_DIS_AUTO_BIT]);
	endproperty
	a_miim_basic_read: assert property (p_miim_basic_read) else $error("alternate crossover read wrong");

	property p_start_clear;
		@(posedge i_clk) disable iff (i_srst)
		start[2] |=> result[2] == CDT_NORMAL && count[2] == 9'h000;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("old result not cleared at start");

	c_test_done: cover property (@(posedge i_clk) disable iff (i_srst) busy[0] ##1 !busy[0]);
	c_miim_start: cover property (@(posedge i_clk) disable iff (i_srst) i_miim_wr && start[1]);
	c_mdix: cover property (@(posedge i_clk) disable iff (i_srst) o_mdix[2]);
endmodule : pcd_phy_ctrl

// ===== hw/pcd_pkg.sv
package pcd_pkg;

	// ==========================================================
	// Register map, byte addresses on the management port
	// ==========================================================
	localparam logic [7:0] CDT_CTRL_OFS [3] = '{8'h1a, 8'h2a, 8'h3a};
	localparam logic [7:0] CDT_RES_OFS [3] = '{8'h1b, 8'h2b, 8'h3b};
	localparam logic [7:0] XOVER_CTRL_OFS [3] = '{8'h1d, 8'h2d, 8'h3d};
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Cable test control fields.
	localparam int CTRL_START_BIT = 4;
	localparam int CTRL_RES_LSB = 5;
	localparam int CTRL_CNT_MSB_BIT = 0;

	// Crossover control fields.
	localparam int XOVER_DIS_AUTO_BIT = 2;
	localparam int XOVER_FORCE_MDI_BIT = 1;

	// Alternate management path: PHY register numbers and fields.
	localparam logic [4:0] MIIM_BASIC_REG = 5'h00;
	localparam logic [4:0] MIIM_CDT_REG = 5'h1d;
	localparam int MIIM_DIS_AUTO_BIT = 5;
	localparam int MIIM_FORCE_MDI_BIT = 4;
	localparam int MIIM_START_BIT = 15;
	localparam int MIIM_RES_LSB = 13;

	// ==========================================================
	// Result codes and link modes
	// ==========================================================
	typedef enum logic [1:0] {
		CDT_NORMAL = 2'h0,
		CDT_OPEN = 2'h1,
		CDT_SHORT = 2'h2,
		CDT_INVALID = 2'h3
	} pcd_result_t;

	typedef enum logic [1:0] {
		MODE_10_HD = 2'h0,
		MODE_10_FD = 2'h1,
		MODE_100_HD = 2'h2,
		MODE_100_FD = 2'h3
	} pcd_mode_t;

	// Ability bit positions in advertisement words.
	localparam int ABIL_100_FD = 3;
	localparam int ABIL_100_HD = 2;
	localparam int ABIL_10_FD = 1;
	localparam int ABIL_10_HD = 0;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_PERIOD_NS = 50;
	localparam int SILENCE_TIMEOUT_NS = 100000;
	localparam int SILENCE_TIMEOUT_CYC = SILENCE_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int FAULT_RANGE_DM = 2000;
	localparam int FAULT_STEP_DM = 4;
	localparam logic [8:0] FAULT_COUNT_MAX = 9'(FAULT_RANGE_DM / FAULT_STEP_DM);

endpackage : pcd_pkg

// ===== tb/pcd_front_model.sv
`timescale 1ns/1ps
module pcd_front_model
	import pcd_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Scenario controls
	input wire logic [2:0] i_coop,
	input wire logic [2:0] i_echo_on,
	input wire logic [2:0] i_short,
	input wire logic [2:0][8:0] i_delay,
	// Device side
	input wire logic [2:0] i_quiet_req,
	input wire logic [2:0] i_tdr_pulse,
	output logic [2:0] o_partner_silent,
	output logic [2:0] o_echo_seen,
	output logic [2:0] o_echo_short
);
	int cnt [3] = '{0, 0, 0};
	logic [2:0] quiet_d = 3'h0;
	logic toggle = 1'b0;

	// The short flag means nothing without an echo, so it wanders then.
	assign o_echo_short = (o_echo_seen & i_short) | (~o_echo_seen & {3{toggle}});

	always @(posedge i_clk) begin
		toggle <= ~toggle;
		for (int p = 0; p < 3; p++) begin
			quiet_d[p] <= i_quiet_req[p];
			o_partner_silent[p] <= i_coop[p] && i_quiet_req[p] && quiet_d[p];
			if (!i_quiet_req[p])
				cnt[p] <= 0;
			else if (i_tdr_pulse[p] || cnt[p] > 0)
				cnt[p] <= cnt[p] + 1;
			o_echo_seen[p] <= i_echo_on[p] && i_quiet_req[p] && cnt[p] >= i_delay[p];
		end
	end
endmodule : pcd_front_model

// ===== tb/pcd_phy_cable_diag_link_mode_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
	$display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module pcd_phy_cable_diag_link_mode_bench
	import pcd_pkg::*;
;
	// ==========================================================
	// Signals
	// ==========================================================
	logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, mwr = 1'b0, mrd = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [1:0] mphy = 2'h0;
	logic [4:0] mreg = 5'h00;
	logic [15:0] mwdata = 16'h0000, mrdata;
	logic [2:0] txp = 3'h0, txn = 3'h0, remote = 3'h0, advv = 3'h0, pd100 = 3'h0, pd10 = 3'h0;
	logic [2:0][1:0] rx1 = '0, rx2 = '0, pair1, pair2, rxd;
	logic [2:0][3:0] ladv = '0, padv = '0;
	pcd_mode_t [2:0] mode;
	logic [2:0] mdix, link, silent, echo, eshort, quiet, pulse;
	logic [2:0] coop = 3'h0, eon = 3'h0, shrt = 3'h0;
	logic [2:0][8:0] dly = '0;
	int bad_count = 0, samples_checked = 0;
	int pulses [3] = '{0, 0, 0};

	always #25 clk = ~clk;

	// Pulses are counted per port so that a skipped measurement shows up.
	always @(posedge clk) begin
		for (int p = 0; p < 3; p++) begin
			if (pulse[p]) pulses[p] <= pulses[p] + 1;
		end
	end

	pcd_phy_ctrl #(.NUM_PORTS(3), .TIMEOUT_CYC(8)) dut (
		.i_clk(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_miim_phy(mphy), .i_miim_reg(mreg),
		.i_miim_wr(mwr), .i_miim_rd(mrd), .i_miim_wdata(mwdata), .o_miim_rdata(mrdata),
		.i_tx_pair_pos(txp), .i_tx_pair_neg(txn), .i_rx_pair1(rx1), .i_rx_pair2(rx2),
		.i_remote_on_pair1(remote), .o_pair1_drive(pair1), .o_pair2_drive(pair2),
		.o_rx_data(rxd), .o_mdix(mdix), .i_local_adv(ladv), .i_partner_adv(padv),
		.i_adv_valid(advv), .i_pd_100(pd100), .i_pd_10(pd10), .o_mode(mode), .o_link_up(link),
		.i_partner_silent(silent), .i_echo_seen(echo), .i_echo_short(eshort),
		.o_quiet_req(quiet), .o_tdr_pulse(pulse));

	pcd_front_model model (
		.i_clk(clk), .i_coop(coop), .i_echo_on(eon), .i_short(shrt), .i_delay(dly),
		.i_quiet_req(quiet), .i_tdr_pulse(pulse), .o_partner_silent(silent),
		.o_echo_seen(echo), .o_echo_short(eshort));

	// ==========================================================
	// Bus tasks
	// ==========================================================
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	// Sampling two edges on is safe because read data stands until the next read.
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		#1 d = rdata;
	endtask : reg_rd

	task automatic mi_wr(input logic [1:0] ph, input logic [4:0] rg, input logic [15:0] d);
		@(posedge clk);
		mphy <= ph;
		mreg <= rg;
		mwdata <= d;
		mwr <= 1'b1;
		@(posedge clk);
		mwr <= 1'b0;
	endtask : mi_wr

	task automatic mi_rd(input logic [1:0] ph, input logic [4:0] rg, output logic [15:0] d);
		@(posedge clk);
		mphy <= ph;
		mreg <= rg;
		mrd <= 1'b1;
		@(posedge clk);
		mrd <= 1'b0;
		@(posedge clk);
		#1 d = mrdata;
	endtask : mi_rd

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	// ==========================================================
	// Scenario tasks
	// ==========================================================
	task automatic route_check(input int p, input logic [7:0] x);
		logic [7:0] v;
		logic mx;
		reg_wr(XOVER_CTRL_OFS[p], x);
		reg_rd(XOVER_CTRL_OFS[p], v);
		`CHK(v, x)
		repeat (4) begin
			@(posedge clk);
			txp <= 3'($urandom);
			txn <= 3'($urandom);
			rx1 <= 6'($urandom);
			rx2 <= 6'($urandom);
			remote <= 3'($urandom);
			@(posedge clk);
			#1 mx = x[2] ? ~x[1] : remote[p];
			`CHK(mdix[p], mx)
			`CHK(pair1[p], mx ? 2'h0 : {txp[p], txn[p]})
			`CHK(pair2[p], mx ? {txp[p], txn[p]} : 2'h0)
			`CHK(rxd[p], mx ? rx1[p] : rx2[p])
		end
	endtask : route_check

	task automatic cable_test(input int p, input bit mi, input bit co, input bit eo, input bit sh, input int d);
		logic [7:0] c;
		logic [7:0] r;
		logic [15:0] m;
		logic [1:0] eres;
		logic [8:0] cnt;
		int n;
		int ecnt;
		int tol;
		int base;
		@(posedge clk);
		coop[p] <= co;
		eon[p] <= eo;
		shrt[p] <= sh;
		dly[p] <= 9'(d);
		eres = !co ? CDT_INVALID : !eo ? CDT_NORMAL : sh ? CDT_SHORT : CDT_OPEN;
		ecnt = !co ? 0 : !eo ? 200 * 10 / 4 : d;
		// Two metres of slack at 0.4 m a count.
		tol = (co && eo) ? 5 : 0;
		base = pulses[p];
		if (mi)
			mi_wr(2'(p + 1), MIIM_CDT_REG, 16'h8000);
		else
			reg_wr(CDT_CTRL_OFS[p], 8'h10);
		for (n = 0; n < 400; n++) begin
			if (mi) begin
				mi_rd(2'(p + 1), MIIM_CDT_REG, m);
				c = {1'b0, m[14:13], m[15], 3'h0, m[8]};
				r = m[7:0];
			end else begin
				reg_rd(CDT_CTRL_OFS[p], c);
				reg_rd(CDT_RES_OFS[p], r);
			end
			if (n == 0) `CHK(c[4], 1'b1)
			if (n == 0) `CHK(quiet[p], 1'b1)
			if (!c[4]) break;
		end
		if (n == 400) begin
			bad_count++;
			tally_and_finish();
		end
		cnt = {c[0], r};
		`CHK(c[6:5], eres)
		`CHK(int'(cnt) >= ecnt - tol && int'(cnt) <= ecnt + tol, 1'b1)
		`CHK(pulses[p] - base, co ? 1 : 0)
		`CHK(quiet[p], 1'b0)
		reg_wr(CDT_RES_OFS[p], 8'hff);
		reg_rd(CDT_RES_OFS[p], r);
		`CHK(r, cnt[7:0])
		reg_rd(CDT_CTRL_OFS[(p + 1) % 3], c);
		`CHK(c[4], 1'b0)
	endtask : cable_test

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		logic [7:0] v;
		logic [15:0] m;
		void'($urandom(32'hcd6b));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		for (int k = 0; k < 10; k++) begin
			reg_rd(k == 9 ? 8'h6e : k < 3 ? CDT_CTRL_OFS[k] : k < 6 ? CDT_RES_OFS[k - 3] : XOVER_CTRL_OFS[k - 6], v);
			`CHK(v, 8'h00)
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			ladv <= {3{4'(1 << k) | 4'($urandom)}};
			padv <= {3{4'(1 << k) | (4'($urandom) & 4'((1 << k) - 1))}};
			advv <= 3'h7;
			repeat (2) @(posedge clk);
			#1 `CHK(mode, {3{2'(k)}})
			`CHK(link, 3'h7)
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			advv <= 3'h0;
			pd100 <= {3{k == 0}};
			pd10 <= {3{k == 1}};
			repeat (2) @(posedge clk);
			#1 `CHK(mode, {3{k == 0 ? MODE_100_HD : MODE_10_HD}})
			`CHK(link, 3'h7)
		end
		for (int p = 0; p < 3; p++) begin
			route_check(p, 8'($urandom) & 8'hfb);
			route_check(p, 8'h06);
			route_check(p, 8'h04);
		end
		reg_wr(8'h6e, 8'ha0);
		reg_wr(8'h6f, 8'h4d);
		reg_wr(8'ha0, 8'h80);
		mi_rd(2'h1, MIIM_BASIC_REG, m);
		`CHK(m[5:4], 2'h2)
		for (int k = 0; k < 5; k++)
			cable_test(k % 3, k == 4, k != 3, k != 2, k == 1, 20 + $urandom_range(280));
		tally_and_finish();
	end
endmodule : pcd_phy_cable_diag_link_mode_bench
